// ===== rtl/adccc_top.sv
// Conversion control for the 10-bit multiplexed analog-to-digital converter
//
// Overview of operation
// - Three-bit select field routes one of eight analog inputs to the converter.
// - Writing the go bit starts one conversion; hardware clears it when done.
// - Done flag sets when result ready; only software clears it.
// - Interrupt requested while done flag and interrupt enable are both set.
// - Quiet bit at start halts the processor during conversion; peripherals keep running.
// - The end of a quiet conversion wakes the processor, whether or not the done interrupt is enabled.
// - Other interrupts arriving during a quiet conversion wait until it ends.
// - Standard conversion gives 8 significant bits; quiet conversion gives 10.
// - Power bit enables converter; clear puts it in standby, no conversion.
// - A conversion takes 11 converter clocks: one sample, ten bit decisions.
// - Straight binary coding, saturating at 3FF in quiet conversion (3FC in standard) and 000.
// - Prescale field zero divides by 64, otherwise by twice its value.
// - Each pin select bit dedicates its port pin to analog input.
// - Result bits 9..2 in high register, bits 1..0 in low register.
`timescale 1ns/10ps
`include "adccc_defs.svh"
module adccc_top
  import adccc_pkg::*;
#(
  parameter int RES_WIDTH = 10,
  parameter int STD_BITS = 8,
  parameter int CHANNELS = 8,
  parameter int DIV_WIDTH = 5
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Special function register access
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  output logic [7:0] sfr_rdata_out,
  output logic sfr_hit_out,
  // Interrupt system
  input wire logic conversion_irq_enable_in,
  input wire logic [7:0] other_irq_pending_in,
  output logic conversion_irq_out,
  output logic [7:0] other_irq_gated_out,
  output logic cpu_halt_out,
  // Analog front end
  output logic [2:0] input_select_field_out,
  output logic converter_power_out,
  output logic [7:0] pin_analog_bits_out,
  output logic sample_hold_out,
  output logic [RES_WIDTH-1:0] trial_code_out,
  input wire logic comparator_in
);
  import adccc_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  adccc_state_type state_ff;
  adccc_state_type nxt_state;
  logic [DIV_WIDTH-1:0] clock_divide_field_ff;
  logic [7:0] analog_pin_select_reg_ff;
  logic quiet_ff;
  logic power_ff;
  logic done_ff;
  logic go_ff;
  logic [2:0] select_ff;
  logic quiet_run_ff;
  logic [RES_WIDTH-1:0] sar_ff;
  logic [RES_WIDTH-1:0] nxt_sar;
  logic [3:0] bit_idx_ff;
  logic [3:0] nxt_bit_idx;
  logic [RES_WIDTH-1:0] result_ff;
  logic cmp_meta_ff;
  logic cmp_sync_ff;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire wr_ctl = sfr_wr_in && (sfr_addr_in == `ADCCC_OFS_CONTROL);
  wire wr_prs = sfr_wr_in && (sfr_addr_in == `ADCCC_OFS_PRESCALE);
  wire wr_pin = sfr_wr_in && (sfr_addr_in == `ADCCC_OFS_PIN_SELECT);
  wire tick;
  wire busy = (state_ff != ADCCC_IDLE);
  wire last_bit = (state_ff == ADCCC_RESOLVE) && tick && (bit_idx_ff == 4'h0);
  // Start needs power; standby ignores the go request
  wire start = go_ff && power_ff && !busy && (state_ff == ADCCC_IDLE);
  wire [RES_WIDTH-1:0] trial = sar_ff | (RES_WIDTH'(1) << bit_idx_ff);
  wire [RES_WIDTH-1:0] std_mask = {{STD_BITS{1'b1}}, {(RES_WIDTH-STD_BITS){1'b0}}};
  // Standard mode keeps only the upper significant bits
  wire [RES_WIDTH-1:0] final_code = quiet_run_ff ? nxt_sar : (nxt_sar & std_mask);
  wire [7:0] ctl_read = {1'b0, quiet_ff, power_ff, done_ff, go_ff, select_ff};

  adccc_prescaler #(
    .DIV_WIDTH(DIV_WIDTH)
  ) u_prescaler (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .run_in(power_ff && busy),
    .divide_in(clock_divide_field_ff),
    .tick_out(tick)
  );

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  // One sample period then one decision per bit, 11 converter clocks total
  always_comb begin
    nxt_state = state_ff;
    nxt_sar = sar_ff;
    nxt_bit_idx = bit_idx_ff;
    unique case (state_ff)
      ADCCC_IDLE: begin
        if (start) begin
          nxt_state = ADCCC_SAMPLE;
          nxt_sar = '0;
          nxt_bit_idx = 4'(RES_WIDTH - 1);
        end
      end
      ADCCC_SAMPLE: begin
        if (tick) begin
          nxt_state = ADCCC_RESOLVE;
        end
      end
      ADCCC_RESOLVE: begin
        if (tick) begin
          // Comparator high keeps the trial bit; saturates naturally at ends
          nxt_sar = cmp_sync_ff ? trial : sar_ff;
          nxt_bit_idx = bit_idx_ff - 4'h1;
          if (bit_idx_ff == 4'h0) begin
            nxt_state = ADCCC_IDLE;
          end
        end
      end
      default: begin
        nxt_state = ADCCC_IDLE;
      end
    endcase
    if (!power_ff) begin
      nxt_state = ADCCC_IDLE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_ff <= ADCCC_IDLE;
      sar_ff <= '0;
      bit_idx_ff <= '0;
      cmp_meta_ff <= 1'b0;
      cmp_sync_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      sar_ff <= nxt_sar;
      bit_idx_ff <= nxt_bit_idx;
      // Comparator is analog-side, so synchronise before use
      // Limitation: the two-cycle lag means divide-by-two decisions see the previous trial
      cmp_meta_ff <= comparator_in;
      cmp_sync_ff <= cmp_meta_ff;
    end
  end

  // ----------------------------------------
  // Control and configuration registers
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      clock_divide_field_ff <= `ADCCC_RST_PRESCALE;
      analog_pin_select_reg_ff <= `ADCCC_RST_PIN_SELECT;
      {quiet_ff, power_ff, done_ff, go_ff, select_ff} <= `ADCCC_RST_CONTROL;
      quiet_run_ff <= 1'b0;
      result_ff <= '0;
    end else begin
      if (wr_prs) begin
        clock_divide_field_ff <= sfr_wdata_in[DIV_WIDTH-1:0];
      end
      if (wr_pin) begin
        analog_pin_select_reg_ff <= sfr_wdata_in;
      end
      if (wr_ctl) begin
        quiet_ff <= sfr_wdata_in[`ADCCC_BIT_QUIET];
        power_ff <= sfr_wdata_in[`ADCCC_BIT_POWER];
        select_ff <= sfr_wdata_in[`ADCCC_SEL_MSB:`ADCCC_SEL_LSB];
      end
      // Go may be set by software but is only cleared by hardware
      if (last_bit || !power_ff) begin
        go_ff <= 1'b0;
      end else if (wr_ctl && sfr_wdata_in[`ADCCC_BIT_GO]) begin
        go_ff <= 1'b1;
      end
      // Set wins over a software clear in the same cycle
      if (last_bit) begin
        done_ff <= 1'b1;
      end else if (wr_ctl && !sfr_wdata_in[`ADCCC_BIT_DONE]) begin
        done_ff <= 1'b0;
      end
      if (start) begin
        quiet_run_ff <= quiet_ff;
      end else if (!busy) begin
        quiet_run_ff <= 1'b0;
      end
      if (last_bit) begin
        result_ff <= final_code;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign input_select_field_out = select_ff;
  assign converter_power_out = power_ff;
  assign pin_analog_bits_out = analog_pin_select_reg_ff;
  assign sample_hold_out = (state_ff == ADCCC_SAMPLE);
  assign trial_code_out = trial;
  assign conversion_irq_out = done_ff && conversion_irq_enable_in;
  // Processor halted through the whole quiet conversion; the sequencer returning to idle releases it
  assign cpu_halt_out = quiet_run_ff && busy;
  // Other requests are held back while the processor is halted
  assign other_irq_gated_out = cpu_halt_out ? 8'h00 : other_irq_pending_in;

  wire hit_ctl = (sfr_addr_in == `ADCCC_OFS_CONTROL);
  wire hit_prs = (sfr_addr_in == `ADCCC_OFS_PRESCALE);
  wire hit_pin = (sfr_addr_in == `ADCCC_OFS_PIN_SELECT);
  wire hit_hi = (sfr_addr_in == `ADCCC_OFS_RESULT_HIGH);
  wire hit_lo = (sfr_addr_in == `ADCCC_OFS_RESULT_LOW);
  assign sfr_hit_out = sfr_rd_in && (hit_ctl || hit_prs || hit_pin || hit_hi || hit_lo);
  assign sfr_rdata_out = !sfr_rd_in ? 8'h00 :
                         hit_ctl ? ctl_read :
                         hit_prs ? {{(8-DIV_WIDTH){1'b0}}, clock_divide_field_ff} :
                         hit_pin ? analog_pin_select_reg_ff :
                         hit_hi ? result_ff[RES_WIDTH-1:RES_WIDTH-8] :
                         hit_lo ? {6'h00, result_ff[1:0]} : 8'h00;
endmodule // adccc_top

// ===== rtl/adccc_defs.svh
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADCCC_DEFS_SVH
`define ADCCC_DEFS_SVH
`define ADCCC_OFS_PRESCALE 8'hF2
`define ADCCC_OFS_CONTROL 8'hF3
`define ADCCC_OFS_RESULT_LOW 8'hF4
`define ADCCC_OFS_RESULT_HIGH 8'hF5
`define ADCCC_OFS_PIN_SELECT 8'hF6
`define ADCCC_RST_PRESCALE 5'h00
`define ADCCC_RST_CONTROL 7'h00
`define ADCCC_RST_PIN_SELECT 8'h00
`define ADCCC_BIT_QUIET 6
`define ADCCC_BIT_POWER 5
`define ADCCC_BIT_DONE 4
`define ADCCC_BIT_GO 3
`define ADCCC_SEL_MSB 2
`define ADCCC_SEL_LSB 0
`define ADCCC_DIV_ZERO_HALF 6'h20
`define ADCCC_CONV_PERIODS 4'hB
`define ADCCC_SETUP_TIME_NS 4000
`define ADCCC_CLK_PERIOD_NS 25
`define ADCCC_SETUP_CYCLES ((`ADCCC_SETUP_TIME_NS + `ADCCC_CLK_PERIOD_NS - 1) / `ADCCC_CLK_PERIOD_NS)
`endif

// ===== rtl/adccc_pkg.sv
// Types of the converter control block
package adccc_pkg;
  typedef enum logic [1:0] {
    ADCCC_IDLE = 2'h0,
    ADCCC_SAMPLE = 2'h1,
    ADCCC_RESOLVE = 2'h3
  } adccc_state_type;
endpackage

// ===== rtl/adccc_prescaler.sv
// Converter clock tick generator from the peripheral clock
`timescale 1ns/10ps
`include "adccc_defs.svh"
module adccc_prescaler #(
  parameter int DIV_WIDTH = 5
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Control
  input wire logic run_in,
  input wire logic [DIV_WIDTH-1:0] divide_in,
  // Tick
  output logic tick_out
);
  logic [DIV_WIDTH:0] cnt_ff;
  logic [DIV_WIDTH:0] nxt_cnt;
  wire [DIV_WIDTH:0] last_count;
  wire wrap;
  // Zero divides by 64; tick every 2*field cycles otherwise
  // Terminal count kept explicit so the 64 case never relies on a shift overflowing
  assign last_count = (divide_in == '0) ? (DIV_WIDTH+1)'((2 * `ADCCC_DIV_ZERO_HALF) - 1)
                                        : ({divide_in, 1'b0} - (DIV_WIDTH+1)'(1));
  assign wrap = (cnt_ff >= last_count);
  assign nxt_cnt = (!run_in || wrap) ? '0 : cnt_ff + (DIV_WIDTH+1)'(1);
  assign tick_out = run_in && wrap;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule // adccc_prescaler

// ===== sim/adccc_props.sv
// Port checker of the converter control
`timescale 1ns/10ps
module adccc_props (
  // Clock, reset and register writes
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  // Interrupts and converter side
  input wire logic conversion_irq_enable_in,
  input wire logic [7:0] other_irq_pending_in,
  input wire logic conversion_irq_out,
  input wire logic [7:0] other_irq_gated_out,
  input wire logic cpu_halt_out,
  input wire logic [2:0] input_select_field_out,
  input wire logic converter_power_out,
  input wire logic [7:0] pin_analog_bits_out,
  input wire logic sample_hold_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire ctl_wr = sfr_wr_in && sfr_addr_in == 8'hF3;
  wire pin_wr = sfr_wr_in && sfr_addr_in == 8'hF6;
  wire [2:0] wsel = sfr_wdata_in[2:0];
  wire wpow = sfr_wdata_in[5];
  a_irq_masked: assert property (!conversion_irq_enable_in |-> !conversion_irq_out)
    else $error("irq without enable");
  a_done_sticky: assert property ($past(conversion_irq_out) && !$past(ctl_wr) &&
    conversion_irq_enable_in |-> conversion_irq_out) else $error("done flag lost");
  a_select_follows: assert property (ctl_wr |=>
    input_select_field_out == $past(wsel)) else $error("select not taken");
  a_power_follows: assert property (ctl_wr |=>
    converter_power_out == $past(wpow)) else $error("power not taken");
  a_pins_follow: assert property (pin_wr |=>
    pin_analog_bits_out == $past(sfr_wdata_in)) else $error("pins not taken");
  a_halt_gates: assert property (cpu_halt_out |-> other_irq_gated_out == 8'h00)
    else $error("irq passed while halted");
  a_run_passes: assert property (!cpu_halt_out |->
    other_irq_gated_out == other_irq_pending_in) else $error("irq held while running");
  a_standby_still: assert property (!converter_power_out [*2] |-> !sample_hold_out)
    else $error("sampling in standby");
endmodule // adccc_props

// ===== sim/adccc_analog_model.sv
// Analog front end model: input multiplexer, sample and hold, comparator
`timescale 1ns/10ps
module adccc_analog_model (
  // Clock
  input wire logic clk_in,
  // Converter controls
  input wire logic [2:0] sel_in,
  input wire logic power_in,
  input wire logic [7:0] pins_in,
  input wire logic hold_in,
  input wire logic [9:0] trial_in,
  // Decision
  output logic cmp_out
);
  int level[8];
  int held = 0;
  logic noise = 1'b0;
  always @(posedge clk_in) begin
    noise <= !noise;
    if (hold_in) begin
      held <= level[sel_in] > 1023 ? 1023 : (level[sel_in] < 0 ? 0 : level[sel_in]);
    end
  end
  // Unpowered or digital pin gives noise, so a stale decision cannot pass
  assign cmp_out = power_in && pins_in[sel_in] ? held >= int'(trial_in) : noise;
endmodule // adccc_analog_model

// ===== sim/test_adccc_top.sv
// Self-checking bench of the converter control
`timescale 1ns/10ps
module test_adccc_top;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ien = 1'b0;
  logic [7:0] a = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] oth = 8'h00;
  logic [7:0] rdata, got, hi, pins;
  logic [9:0] trial;
  logic [2:0] sel;
  logic irq, halt, pwr, sh, cmp;
  logic hit, hit_seen;
  int fail_count = 0;
  int compares = 0;
  int seed = 32'h1eb9;
  int n, v, d, p;
  adccc_top u_dut (.clk_in, .reset_in, .sfr_addr_in(a), .sfr_wdata_in(wd), .sfr_wr_in(wr),
    .sfr_rd_in(rd), .sfr_rdata_out(rdata), .sfr_hit_out(hit), .conversion_irq_enable_in(ien),
    .other_irq_pending_in(oth), .conversion_irq_out(irq), .other_irq_gated_out(),
    .cpu_halt_out(halt), .input_select_field_out(sel), .converter_power_out(pwr),
    .pin_analog_bits_out(pins), .sample_hold_out(sh), .trial_code_out(trial),
    .comparator_in(cmp));
  adccc_analog_model u_far (.clk_in, .sel_in(sel), .power_in(pwr), .pins_in(pins),
    .hold_in(sh), .trial_in(trial), .cmp_out(cmp));
  initial begin
    forever #12.5 clk_in = !clk_in;
  end
  always @(posedge clk_in) begin
    oth <= $random(seed);
  end
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] ad, input logic [7:0] dv);
    @(posedge clk_in);
    a <= ad;
    wd <= dv;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] ad);
    @(posedge clk_in);
    a <= ad;
    rd <= 1'b1;
    @(negedge clk_in);
    got = rdata;
    hit_seen = hit;
    @(posedge clk_in);
    rd <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int r = 8'hF1; r < 8'hF8; r++) begin
      rreg(r[7:0]);
      chk(got, 0);
      chk(hit_seen, r >= 8'hF2 && r <= 8'hF6);
    end
    wreg(8'hF3, 8'h08);
    rreg(8'hF3);
    chk(got, 8'h00);
    wreg(8'hF6, 8'h5A);
    rreg(8'hF6);
    chk(got, 8'h5A);
    wreg(8'hF6, 8'hFF);
    wreg(8'hF3, 8'h30);
    rreg(8'hF3);
    chk(got, 8'h20);
    for (int i = 0; i < 8; i++) begin
      u_far.level[i] = $random(seed) % 1400;
    end
    ien <= 1'b1;
    repeat (160) @(posedge clk_in);
    // Last pass: fastest divider on an over-range input, whose decisions do not
    // depend on the comparator lag
    for (int c = 0; c < 9; c++) begin
      p = c == 8 ? 1 : (c % 3 == 2 ? 0 : c % 3 + 2);
      d = p == 0 ? 64 : 2 * p;
      if (c == 8) begin
        u_far.level[0] = 1500;
      end
      v = u_far.level[c[2:0]] > 1023 ? 1023 :
          (u_far.level[c[2:0]] < 0 ? 0 : u_far.level[c[2:0]]);
      wreg(8'hF2, p[7:0]);
      rreg(8'hF2);
      chk(got, p);
      wreg(8'hF3, {1'b0, c[0], 3'b101, c[2:0]});
      // Read held open so the done cycle is seen the moment it lands
      a <= 8'hF3;
      rd <= 1'b1;
      n = 0;
      while (irq !== 1'b1) begin
        @(negedge clk_in);
        n++;
        if (n == 5) begin
          chk(rdata[3], 1);
          chk(halt, c[0]);
        end
        if (n > 3000) begin
          fail_count++;
          give_verdict;
        end
      end
      chk(n >= 11 * d && n <= 11 * d + 4, 1);
      chk(rdata, {1'b0, c[0], 3'b110, c[2:0]});
      @(posedge clk_in);
      rd <= 1'b0;
      rreg(8'hF5);
      hi = got;
      rreg(8'hF4);
      chk({hi, got[1:0]}, c[0] ? v : v & 10'h3FC);
      chk(got[7:2], 0);
      @(posedge clk_in);
      ien <= 1'b0;
      @(negedge clk_in);
      chk(irq, 0);
      @(posedge clk_in);
      ien <= 1'b1;
      @(negedge clk_in);
      chk(irq, 1);
      wreg(8'hF3, 8'h20);
      @(negedge clk_in);
      chk(irq, 0);
    end
    give_verdict;
  end
endmodule // test_adccc_top
bind adccc_top adccc_props u_props (.clk_in, .reset_in, .sfr_addr_in, .sfr_wdata_in,
  .sfr_wr_in, .conversion_irq_enable_in, .other_irq_pending_in, .conversion_irq_out,
  .other_irq_gated_out, .cpu_halt_out, .input_select_field_out, .converter_power_out,
  .pin_analog_bits_out, .sample_hold_out);
